// ==== rtl/sfr_pkg.sv ====
// shared timing constants and state types for the flash reset sequencer
package sfr_pkg;
   // clock rate in kHz, 100 MHz
   localparam int CLK_KHZ = 100000;
   // absolute times as printed
   localparam int POWER_UP_DELAY_US = 300;
   localparam int RESET_HIGH_SETUP_TIME_NS = 50;
   localparam int RESET_RECOVERY_TIME_US = 35;
   localparam int RESET_PULSE_MIN_WIDTH_NS = 200;
   localparam int RESET_RELEASE_HOLD_TIME_NS = 50;
   // cycle counts, minimum times rounded up, setup time one cycle more
   localparam int POWER_UP_CYC = (POWER_UP_DELAY_US * CLK_KHZ + 999) / 1000;
   localparam int SETUP_CYC = (RESET_HIGH_SETUP_TIME_NS * CLK_KHZ + 999999) / 1000000 + 1;
   localparam int RECOVERY_CYC = (RESET_RECOVERY_TIME_US * CLK_KHZ + 999) / 1000;
   localparam int PULSE_CYC = (RESET_PULSE_MIN_WIDTH_NS * CLK_KHZ + 999999) / 1000000;
   localparam int HOLD_CYC = (RESET_RELEASE_HOLD_TIME_NS * CLK_KHZ + 999999) / 1000000;
   localparam int CNT_W = 16;

   // device sequencer states
   typedef enum logic [2:0] {
      SFR_POR     = 3'b000,
      SFR_HOLD    = 3'b001,
      SFR_STANDBY = 3'b011,
      SFR_ACTIVE  = 3'b010,
      SFR_WARM    = 3'b110
   } sfr_dev_state_t;

   // host sequencer states
   typedef enum logic [2:0] {
      SFR_H_PU    = 3'b000,
      SFR_H_IDLE  = 3'b001,
      SFR_H_PULSE = 3'b011,
      SFR_H_RHOLD = 3'b010,
      SFR_H_SETUP = 3'b110
   } sfr_host_state_t;
endpackage

// ==== rtl/sfr_link_if.sv ====
// interface joining host and flash reset sequencer ends
interface sfr_link_if;
   logic cs_n;     // chip select, host drives
   logic reset_n;  // reset pin, host drives
   modport device (input cs_n, input reset_n);
   modport host   (output cs_n, output reset_n);
endinterface

// ==== rtl/sfr_device.sv ====
// flash-side reset and power-state sequencer
// What this block and the host do
// R1 - full power-up delay before any operation
// R2 - host keeps select high during power-up
// R3 - reset pin ignored during power-on init
// R4 - reset low at power-up end holds reset
// R5 - host waits hold time after reset release
// R6 - reset high for setup time before low
// R7 - falling reset restores state within recovery
// R8 - failed init makes reset rerun full init
// R9 - valid reset aborts, tri-states, ignores commands
// R10 - host raises select during recovery
// R11 - pulse width plus hold covers recovery
// R12 - active while selected or operations pending
// R13 - init ends in standby, latch cleared
// R14 - power-up delay at most 300 us
// R15 - delays counted on free clock, rounded up
//
// the first sampled low of the reset pin starts a reset at once; a
// glitch shorter than the minimum pulse width is not filtered out
// a fall inside recovery is ignored; the host must wait out the setup
// time before pulling the pin low again
// a pin still low when a timed delay ends parks the device in hold
// the write enable latch has no set path in this block, only clears
// por_ok is sampled once, on the last cycle of the power-up delay
module sfr_device #(
   parameter int POWER_UP_CYCLES = sfr_pkg::POWER_UP_CYC
) (
   // clock and supply-good reset
   input  wire logic mclk,
   input  wire logic rst_n,
   // link to host
   sfr_link_if.device link,
   // user side
   input  wire logic por_ok,
   input  wire logic op_pending,
   output logic      ready,
   output logic      active,
   output logic      out_en,
   output logic      abort,
   output logic      write_enable_latch,
   output logic      in_reset
);
   // last values of the two delay counts
   localparam logic [sfr_pkg::CNT_W-1:0] PU_LAST = sfr_pkg::CNT_W'(POWER_UP_CYCLES - 1);
   localparam logic [sfr_pkg::CNT_W-1:0] RP_LAST = sfr_pkg::CNT_W'(sfr_pkg::RECOVERY_CYC - 1);

   // sequencer state and its delay counter
   sfr_pkg::sfr_dev_state_t   state;
   logic [sfr_pkg::CNT_W-1:0] cnt;
   // reset pin edge detection and the last power-on outcome
   logic                      reset_q;
   logic                      init_good;
   // decoded conditions shared by the processes below
   logic                      fall;
   logic                      pu_done;
   logic                      rec_done;
   logic                      serving;

   // a fall is a step between two edges; the edge register idles high
   assign fall = reset_q & ~link.reset_n;
   // terminal counts of the two timed states
   assign pu_done = (state == sfr_pkg::SFR_POR) && (cnt == PU_LAST);
   assign rec_done = (state == sfr_pkg::SFR_WARM) && (cnt == RP_LAST);
   // states in which the device answers the host
   assign serving = (state == sfr_pkg::SFR_STANDBY) || (state == sfr_pkg::SFR_ACTIVE);

   // previous reset pin level for edge detection; it idles high like
   // the pin, so no false fall follows reset
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         reset_q <= 1'b1;
      end else begin
         reset_q <= link.reset_n;
      end
   end

   // state sequencer; only a counted delay, a pin level or op_pending moves it
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         state <= sfr_pkg::SFR_POR;
      end else begin
         unique case (state)
            sfr_pkg::SFR_POR: begin
               // reset pin not looked at until the full delay ends
               if (pu_done) begin // R1 R3 R14
                  state <= link.reset_n ? sfr_pkg::SFR_STANDBY : sfr_pkg::SFR_HOLD; // R4
               end
            end
            sfr_pkg::SFR_HOLD: begin
               // pin still low after a timed delay: wait for its release
               if (link.reset_n) begin // R4
                  state <= sfr_pkg::SFR_STANDBY;
               end
            end
            sfr_pkg::SFR_STANDBY, sfr_pkg::SFR_ACTIVE: begin
               // a fall after a failed power-on reruns the full delay
               if (fall && !init_good) begin // R8
                  state <= sfr_pkg::SFR_POR;
               end else if (fall) begin // R7
                  state <= sfr_pkg::SFR_WARM;
               end else if (!link.cs_n || op_pending) begin // R12
                  state <= sfr_pkg::SFR_ACTIVE;
               end else begin
                  state <= sfr_pkg::SFR_STANDBY;
               end
            end
            sfr_pkg::SFR_WARM: begin
               // recovery counted from the falling edge, later falls ignored
               if (rec_done) begin // R7 R9
                  state <= link.reset_n ? sfr_pkg::SFR_STANDBY : sfr_pkg::SFR_HOLD;
               end
            end
            default: begin
               // unused code: restart the full power-on run
               state <= sfr_pkg::SFR_POR;
            end
         endcase
      end
   end

   // delay counter: runs only in the two timed states, zero elsewhere,
   // and starts from zero on every entry into either of them
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         cnt <= '0;
      end else if (pu_done || rec_done || (fall && serving)) begin // R15
         cnt <= '0;
      end else if (state == sfr_pkg::SFR_POR || state == sfr_pkg::SFR_WARM) begin // R15
         cnt <= cnt + 1'b1;
      end else begin
         cnt <= '0;
      end
   end

   // outcome of the power-on run, taken as its delay ends; it decides
   // whether the next fall is a warm reset or a full rerun
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         init_good <= 1'b0;
      end else if (pu_done) begin // R8
         init_good <= por_ok;
      end
   end

   // operations accepted only while serving; refused from the edge of a fall
   // so no command slips in on the cycle the reset is seen
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         ready <= 1'b0;
      end else begin
         ready <= serving && !fall; // R1 R9
      end
   end

   // active power state, kept while selected or while work is pending;
   // it lags the state register by one cycle
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         active <= 1'b0;
      end else begin
         active <= (state == sfr_pkg::SFR_ACTIVE); // R12
      end
   end

   // outputs driven only while selected and serving; a fall releases them
   // at once rather than after the minimum pulse width
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         out_en <= 1'b0;
      end else begin
         out_en <= (state == sfr_pkg::SFR_ACTIVE) && !link.cs_n && !fall; // R9
      end
   end

   // one-cycle pulse when a fall cuts an operation in progress; a fall
   // in standby has nothing to abort
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         abort <= 1'b0;
      end else begin
         abort <= fall && (state == sfr_pkg::SFR_ACTIVE); // R9
      end
   end

   // reset flag for the user side, high in every timed or holding state;
   // it rises one cycle after the fall is seen
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         in_reset <= 1'b1;
      end else begin
         in_reset <= (state == sfr_pkg::SFR_POR || state == sfr_pkg::SFR_HOLD
                      || state == sfr_pkg::SFR_WARM); // R4
      end
   end

   // write enable latch, cleared by any reset path: held clear in every
   // state but serving, and cleared on the edge of a fall; nothing in
   // this block sets it
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         write_enable_latch <= 1'b0;
      end else if (state != sfr_pkg::SFR_ACTIVE && state != sfr_pkg::SFR_STANDBY) begin
         write_enable_latch <= 1'b0; // R13
      end else if (fall) begin
         write_enable_latch <= 1'b0; // R7
      end
   end
endmodule // sfr_device

// ==== rtl/sfr_host.sv ====
// host-side driver of chip select and reset pin timing
module sfr_host #(
   parameter int POWER_UP_CYCLES = sfr_pkg::POWER_UP_CYC
) (
   // clock and reset
   input  wire logic mclk,
   input  wire logic rst_n,
   // link to flash
   sfr_link_if.host  link,
   // user side
   input  wire logic rst_req,
   input  wire logic sel_req,
   output logic      sel_ok,
   output logic      busy
);
   localparam logic [sfr_pkg::CNT_W-1:0] PU_LAST = sfr_pkg::CNT_W'(POWER_UP_CYCLES - 1);
   // pulse stretched so pulse plus hold covers recovery
   localparam int PW = (sfr_pkg::PULSE_CYC + sfr_pkg::HOLD_CYC < sfr_pkg::RECOVERY_CYC)
                       ? sfr_pkg::RECOVERY_CYC - sfr_pkg::HOLD_CYC : sfr_pkg::PULSE_CYC;
   localparam logic [sfr_pkg::CNT_W-1:0] PW_LAST = sfr_pkg::CNT_W'(PW - 1);
   localparam logic [sfr_pkg::CNT_W-1:0] RH_LAST = sfr_pkg::CNT_W'(sfr_pkg::HOLD_CYC - 1);
   localparam logic [sfr_pkg::CNT_W-1:0] RS_LAST = sfr_pkg::CNT_W'(sfr_pkg::SETUP_CYC - 1);

   sfr_pkg::sfr_host_state_t state;
   logic [sfr_pkg::CNT_W-1:0] cnt;

   // sequencer for the two pins
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         state <= sfr_pkg::SFR_H_PU;
         cnt <= '0;
         link.cs_n <= 1'b1;
         link.reset_n <= 1'b1;
         sel_ok <= 1'b0;
         busy <= 1'b1;
      end else begin
         unique case (state)
            sfr_pkg::SFR_H_PU: begin
               link.cs_n <= 1'b1; // R2
               if (cnt == PU_LAST) begin // R15
                  cnt <= '0;
                  state <= sfr_pkg::SFR_H_SETUP; // R6
               end else begin
                  cnt <= cnt + 1'b1;
               end
            end
            sfr_pkg::SFR_H_SETUP: begin
               if (cnt == RS_LAST) begin // R6
                  cnt <= '0;
                  state <= sfr_pkg::SFR_H_IDLE;
                  sel_ok <= 1'b1;
                  busy <= 1'b0;
               end else begin
                  cnt <= cnt + 1'b1;
               end
            end
            sfr_pkg::SFR_H_IDLE: begin
               if (rst_req) begin
                  link.reset_n <= 1'b0;
                  link.cs_n <= 1'b1; // R10
                  sel_ok <= 1'b0;
                  busy <= 1'b1;
                  state <= sfr_pkg::SFR_H_PULSE;
               end else begin
                  link.cs_n <= ~sel_req;
               end
            end
            sfr_pkg::SFR_H_PULSE: begin
               link.cs_n <= 1'b1; // R10
               if (cnt == PW_LAST) begin // R11
                  cnt <= '0;
                  link.reset_n <= 1'b1;
                  state <= sfr_pkg::SFR_H_RHOLD;
               end else begin
                  cnt <= cnt + 1'b1;
               end
            end
            sfr_pkg::SFR_H_RHOLD: begin
               if (cnt == RH_LAST) begin // R5
                  cnt <= '0;
                  state <= sfr_pkg::SFR_H_SETUP; // R6
               end else begin
                  cnt <= cnt + 1'b1;
               end
            end
            default: begin
               state <= sfr_pkg::SFR_H_PU;
               cnt <= '0;
            end
         endcase
      end
   end
endmodule // sfr_host

// ==== tb/sfr_link_checker.sv ====
// assertions on the chip select and reset pin link between host and flash
module sfr_link_checker #(
   parameter int POWER_UP_CYCLES = sfr_pkg::POWER_UP_CYC
) (
   // clock and reset
   input wire logic mclk,
   input wire logic rst_n,
   // link pins
   input wire logic cs_n,
   input wire logic reset_n
);
   timeunit 1ns;
   timeprecision 1ps;
   int unsigned up_cnt;
   int unsigned lo_cnt;
   int unsigned hi_cnt;
   default clocking @(posedge mclk); endclocking
   default disable iff (!rst_n);
   // cycles since release, and run lengths of each reset pin level
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         up_cnt <= 0;
         lo_cnt <= 0;
         hi_cnt <= 0;
      end else begin
         up_cnt <= (up_cnt < POWER_UP_CYCLES) ? up_cnt + 1 : up_cnt;
         lo_cnt <= reset_n ? 0 : lo_cnt + 1;
         hi_cnt <= reset_n ? hi_cnt + 1 : 0;
      end
   end
   pu_deselect_a: assert property (up_cnt < POWER_UP_CYCLES |-> cs_n && reset_n)
      else $error("link driven during power-up");
   pulse_deselect_a: assert property (!reset_n |-> cs_n)
      else $error("select low while reset pin low");
   release_hold_a: assert property ($rose(reset_n) |-> cs_n [*5])
      else $error("select low inside release hold");
   pulse_sum_a: assert property ($rose(reset_n) |->
                                 lo_cnt >= sfr_pkg::RECOVERY_CYC - sfr_pkg::HOLD_CYC)
      else $error("reset pulse plus hold below recovery");
   pulse_width_a: assert property ($rose(reset_n) |-> lo_cnt >= sfr_pkg::PULSE_CYC)
      else $error("reset pulse too short");
   setup_time_a: assert property ($fell(reset_n) |-> hi_cnt >= sfr_pkg::SETUP_CYC)
      else $error("reset pin high too briefly before fall");
   // main scenarios reached
   cover property ($fell(reset_n));
   cover property ($rose(reset_n));
   cover property ($fell(cs_n));
endmodule // sfr_link_checker

// ==== tb/testbench.sv ====
// self-checking bench for the joined host and flash reset sequencers
module testbench;
   timeunit 1ns;
   timeprecision 1ps;
   localparam int PU = 50;
   logic mclk = 0;
   logic rst_n = 0;
   logic por_ok = 1;
   logic op_pending = 0;
   logic rst_req = 0;
   logic sel_req = 0;
   logic aborted = 0;
   logic ready, active, out_en, abort, write_enable_latch, in_reset, sel_ok, busy;
   int err_count = 0;
   int total_checks = 0;
   int n;
   sfr_link_if link ();
   sfr_device #(.POWER_UP_CYCLES(PU)) i_sfr_device (.mclk(mclk), .rst_n(rst_n),
      .link(link), .por_ok(por_ok), .op_pending(op_pending), .ready(ready),
      .active(active), .out_en(out_en), .abort(abort),
      .write_enable_latch(write_enable_latch), .in_reset(in_reset));
   sfr_host #(.POWER_UP_CYCLES(PU)) i_sfr_host (.mclk(mclk), .rst_n(rst_n), .link(link),
      .rst_req(rst_req), .sel_req(sel_req), .sel_ok(sel_ok), .busy(busy));
   sfr_link_checker #(.POWER_UP_CYCLES(PU)) i_sfr_link_checker (.mclk(mclk),
      .rst_n(rst_n), .cs_n(link.cs_n), .reset_n(link.reset_n));
   // 100 MHz clock
   always #5 mclk = ~mclk;
   // catches the one-cycle abort pulse
   always @(posedge mclk) if (abort === 1'b1) aborted <= 1'b1;
   task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
      total_checks++;
      if (seen !== exp) begin
         err_count++;
         $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task automatic complete_run();
      if (err_count == 0 && total_checks > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask
   // counts cycles until ready, in_reset or sel_ok is high, bounded
   task automatic wait_hi(input int sel, input int lim);
      n = 0;
      while ((sel == 0 ? ready : sel == 1 ? in_reset : sel_ok) !== 1'b1) begin
         @(negedge mclk);
         n++;
         if (n > lim) begin
            err_count++;
            complete_run();
         end
      end
   endtask
   // supply-good reset with a chosen init outcome
   task automatic power_up(input logic ok);
      rst_n = 0;
      por_ok = ok;
      repeat (5) @(negedge mclk);
      chk({ready, in_reset, write_enable_latch, sel_ok, busy, link.cs_n, link.reset_n},
          16'h0027);
      rst_n = 1;
   endtask
   // one warm reset request through the host
   task automatic warm_reset();
      @(negedge mclk);
      rst_req = 1;
      @(negedge mclk);
      rst_req = 0;
      wait_hi(1, 10);
   endtask
   // main sequence
   initial begin
      power_up(1);
      wait_hi(0, PU + 20);
      chk(n >= PU, 1);
      chk({active, write_enable_latch, in_reset}, 16'h0000);
      wait_hi(2, 20);
      chk(busy, 16'h0000);
      sel_req = 1;
      repeat (3) @(negedge mclk);
      chk({link.cs_n, active, out_en}, 16'h0003);
      op_pending = 1;
      sel_req = 0;
      repeat (3) @(negedge mclk);
      chk({link.cs_n, active, out_en}, 16'h0006);
      op_pending = 0;
      repeat (3) @(negedge mclk);
      chk(active, 16'h0000);
      sel_req = 1;
      repeat (3) @(negedge mclk);
      warm_reset();
      chk({in_reset, ready, out_en, link.cs_n}, 16'h0009);
      chk({busy, sel_ok}, 16'h0002);
      wait_hi(0, sfr_pkg::RECOVERY_CYC + 20);
      chk(n >= sfr_pkg::RECOVERY_CYC - 2, 1);
      chk(aborted, 16'h0001);
      sel_req = 0;
      power_up(0);
      wait_hi(2, PU + 30);
      por_ok = 1;
      warm_reset();
      wait_hi(0, sfr_pkg::RECOVERY_CYC + 20);
      chk(ready, 16'h0001);
      chk(n <= sfr_pkg::RECOVERY_CYC - sfr_pkg::HOLD_CYC + 2, 1);
      chk(link.reset_n, 16'h0001);
      complete_run();
   end
endmodule // testbench
